// file: hw/compare_branch_pkg.sv
package compare_branch_pkg;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam int MEM_DEPTH = 256;
	localparam int MEM_SEL_BIT = 10;
	localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] OFF_INSTR = 12'h004;
	localparam logic [APB_AW-1:0] OFF_ADDR = 12'h008;
	localparam logic [APB_AW-1:0] OFF_STATUS = 12'h00C;
	localparam logic [APB_AW-1:0] OFF_IAR = 12'h010;
	localparam logic [APB_AW-1:0] OFF_MEM = 12'h400;

	localparam int CTRL_START = 0;
	localparam int CTRL_SCAN = 1;
	localparam int CTRL_OVF = 3;
	localparam int IN_OP = 0;
	localparam int IN_AF = 8;
	localparam int IN_BF = 16;
	localparam int AD_A = 0;
	localparam int AD_B = 8;
	localparam int AD_C = 16;
	localparam int ST_IND = 0;
	localparam int ST_OVF = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_FOUND = 4;
	localparam int ST_ERR = 5;
	localparam int ST_IAR = 8;
	localparam int ST_HIT = 16;
	localparam int ST_RET = 24;

	localparam logic [7:0] OP_NO_OPERATION = 8'h20;
	localparam logic [7:0] OP_BRANCH_IF_LOW = 8'h21;
	localparam logic [7:0] OP_BRANCH_IF_EQUAL = 8'h22;
	localparam logic [7:0] OP_BRANCH_IF_LOW_OR_EQUAL = 8'h23;
	localparam logic [7:0] OP_BRANCH_IF_HIGH = 8'h24;
	localparam logic [7:0] OP_BRANCH_IF_DIFFERS = 8'h25;
	localparam logic [7:0] OP_BRANCH_IF_HIGH_OR_EQUAL = 8'h26;
	localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h27;
	localparam logic [7:0] OP_BRANCH_ON_OVERFLOW = 8'h28;
	localparam logic [7:0] OP_SUBROUTINE_ENTRY = 8'h31;
	localparam logic [7:0] OP_FIELD_SCAN_MASK = 8'h34;
	localparam logic [7:0] OP_FIELD_XOR = 8'h44;
	localparam logic [7:0] OP_COMPARE_ALPHANUMERIC = 8'h45;
	localparam logic [7:0] OP_COMPARE_NUMERIC = 8'h46;
	localparam logic [7:0] OP_FORMAT_EDIT = 8'h49;

	localparam logic [1:0] IND_LOW = 2'h1;
	localparam logic [1:0] IND_EQUAL = 2'h2;
	localparam logic [1:0] IND_HIGH = 2'h3;
	localparam logic [1:0] SCAN_EQUAL = 2'h0;
	localparam logic [1:0] SCAN_LOW = 2'h1;
	localparam logic [1:0] SCAN_LOWEST = 2'h2;

	localparam logic [6:0] LEN_FULL = 7'h64;
	localparam logic [7:0] PAD_CHAR = 8'h20;
	localparam logic [7:0] PAD_ONES = 8'hFF;
	localparam logic [7:0] MO_COPY = 8'h00;
	localparam logic [7:0] STEP_SYL1 = 8'h06;
	localparam logic [7:0] STEP_SYL2 = 8'h0A;
	localparam logic [7:0] STEP_SYL3 = 8'h0E;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CMP = 3'h1,
		S_SCAN_NEXT = 3'h3,
		S_XOR = 3'h2,
		S_EDIT = 3'h6
	} state_t;

	typedef struct packed {
		state_t state;
		logic [7:0] op;
		logic [7:0] af;
		logic [7:0] bf;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] iar;
		logic [7:0] ret;
		logic [7:0] hit;
		logic [7:0] p;
		logic [7:0] best;
		logic [1:0] ind;
		logic [1:0] scan;
		logic ovf;
		logic found;
		logic err;
		logic [6:0] i;
		logic [6:0] k;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} regs_t;

	localparam regs_t REGS_RESET = '{state: S_IDLE, ind: IND_EQUAL, default: '0};
endpackage

// file: hw/compare_branch_logic_exec.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
// Operation
// - opcode 44 is a three-syllable field XOR laid out like AND
// - each XOR result bit is one when exactly one input bit is one
// - shorter XOR operand is extended with trailing one bits
// - logical field lengths 1 to 100, code 00 means 100
// - logical result is as long as the longer operand, written at C
// - opcode 34 searches B toward C, mask length, increment, search kind
// - opcode 45 compares A characters against B, sets low/equal/high
// - alphanumeric compare lengths come separately from both variants
// - opcode 46 compares numeric A with B and sets the indicators
// - numeric lengths 01 to 99 digits, 00 means 100
// - shorter numeric field is taken with leading zero digits
// - opcode 49 copies A into C formatted by micro-operators at B
// - edit micro-operator count from second variant, 00 means 100
// - opcode 20 only advances to the next instruction
// - opcode 21 branches only on low
// - opcode 22 branches only on equal
// - opcode 23 branches on equal or low
// - opcode 24 branches only on high
// - opcode 25 branches on high or low
// - opcode 26 branches on equal or high
// - opcode 27 always branches, ignoring the indicators
// - opcode 28 branches when the overflow flag is set
// - opcode 31 enters a subroutine, return resumes past it and parameters
module compare_branch_logic_exec (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [compare_branch_pkg::APB_AW-1:0] paddr,
	input wire logic [compare_branch_pkg::APB_DW-1:0] pwdata,
	output logic [compare_branch_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	import compare_branch_pkg::*;

	regs_t r;
	regs_t d;
	logic [7:0] mem [0:MEM_DEPTH-1];
	logic mem_we;
	logic [7:0] mem_wa;
	logic [7:0] mem_wd;

	function automatic logic [6:0] len_of(input logic [7:0] code);
		logic [6:0] v;
		v = 7'({3'h0, code[7:4]} * 7'h0A) + {3'h0, code[3:0]};
		return (code == 8'h00) ? LEN_FULL : v;
	endfunction

	function automatic logic [7:0] param_count(input logic [7:0] hi,
		input logic [7:0] lo);
		logic [13:0] v;
		v = 14'({10'h0, hi[7:4]} * 14'h03E8) + 14'({10'h0, hi[3:0]} * 14'h0064)
			+ 14'({10'h0, lo[7:4]} * 14'h000A) + {10'h0, lo[3:0]};
		return v[7:0];
	endfunction

	function automatic logic [7:0] syl_step(input logic [7:0] op);
		case (op)
			OP_FIELD_XOR, OP_FIELD_SCAN_MASK, OP_FORMAT_EDIT: return STEP_SYL3;
			OP_COMPARE_ALPHANUMERIC, OP_COMPARE_NUMERIC: return STEP_SYL2;
			default: return STEP_SYL1;
		endcase
	endfunction

	function automatic logic branch_taken(input logic [7:0] op,
		input logic [1:0] ind, input logic ovf);
		case (op)
			OP_BRANCH_IF_LOW: return ind == IND_LOW;
			OP_BRANCH_IF_EQUAL: return ind == IND_EQUAL;
			OP_BRANCH_IF_LOW_OR_EQUAL: return ind != IND_HIGH;
			OP_BRANCH_IF_HIGH: return ind == IND_HIGH;
			OP_BRANCH_IF_DIFFERS: return ind != IND_EQUAL;
			OP_BRANCH_IF_HIGH_OR_EQUAL: return ind != IND_LOW;
			OP_BRANCH_ALWAYS: return 1'b1;
			OP_BRANCH_ON_OVERFLOW: return ovf;
			default: return 1'b0;
		endcase
	endfunction

	// alpha fields align left and pad at the end; numeric fields align right
	function automatic logic [7:0] fetch(input logic [7:0] base,
		input logic [6:0] len, input logic [6:0] n, input logic [6:0] idx,
		input logic numeric, input logic [7:0] pad);
		logic [6:0] off;
		logic [7:0] v;
		off = 7'(n - len);
		v = 8'h00;
		if (numeric) begin
			if (idx >= off)
				v = {4'h0, mem[8'(base + {1'b0, 7'(idx - off)})][3:0]};
		end else if (idx < len) begin
			v = mem[8'(base + {1'b0, idx})];
		end else begin
			v = pad;
		end
		return v;
	endfunction

	always_comb begin
		logic [6:0] xl;
		logic [6:0] yl;
		logic [6:0] n;
		logic [7:0] xbase;
		logic [7:0] ybase;
		logic [7:0] xb;
		logic [7:0] yb;
		logic [7:0] pad;
		logic [7:0] mo;
		logic [7:0] step;
		logic [8:0] nxt;
		logic [6:0] inc;
		logic numeric;
		logic last;
		logic lt;
		logic gt;
		logic setup;
		logic wr;
		logic is_mem;
		logic busy;
		logic start;
		d = r;
		xl = len_of(r.af);
		yl = len_of(r.bf);
		// scan entries step by the second variant; the mask length only
		// sets how many bytes of each entry take part in the compare
		inc = len_of(r.bf);
		xbase = r.a;
		ybase = r.b;
		numeric = 1'b0;
		pad = PAD_CHAR;
		case (r.op)
			OP_COMPARE_NUMERIC: numeric = 1'b1;
			// ones as padding make the tail the inverse of the longer field
			OP_FIELD_XOR: pad = PAD_ONES;
			OP_FIELD_SCAN_MASK: begin
				xbase = r.p;
				yl = xl;
				ybase = (r.scan == SCAN_LOWEST && r.found) ? r.best : r.a;
			end
			default: begin
			end
		endcase
		n = (xl > yl) ? xl : yl;
		xb = fetch(xbase, xl, n, r.i, numeric, pad);
		yb = fetch(ybase, yl, n, r.i, numeric, pad);
		lt = xb < yb;
		gt = xb > yb;
		last = r.i == 7'(n - 7'h01);
		mo = mem[8'(r.b + {1'b0, r.i})];
		step = syl_step(r.op);
		nxt = {1'b0, r.p} + {2'b00, inc};
		busy = r.state != S_IDLE;

		// register read data is captured in setup so pready can be a flop
		setup = psel & ~penable;
		wr = psel & penable & r.pready & pwrite & ~r.pslverr;
		is_mem = paddr[MEM_SEL_BIT];
		d.pready = setup;
		d.pslverr = 1'b0;
		d.prdata = '0;
		if (setup) begin
			if (is_mem) begin
				d.prdata = {24'h0, mem[paddr[9:2]]};
				d.pslverr = paddr[APB_AW-1:MEM_SEL_BIT+1] != '0;
			end else begin
				case (paddr)
					OFF_CTRL: begin
						d.prdata[CTRL_SCAN +: 2] = r.scan;
						d.prdata[CTRL_OVF] = r.ovf;
					end
					OFF_INSTR: begin
						d.prdata[IN_OP +: 8] = r.op;
						d.prdata[IN_AF +: 8] = r.af;
						d.prdata[IN_BF +: 8] = r.bf;
					end
					OFF_ADDR: begin
						d.prdata[AD_A +: 8] = r.a;
						d.prdata[AD_B +: 8] = r.b;
						d.prdata[AD_C +: 8] = r.c;
					end
					OFF_STATUS: begin
						d.prdata[ST_IND +: 2] = r.ind;
						d.prdata[ST_OVF] = r.ovf;
						d.prdata[ST_BUSY] = busy;
						d.prdata[ST_FOUND] = r.found;
						d.prdata[ST_ERR] = r.err;
						d.prdata[ST_IAR +: 8] = r.iar;
						d.prdata[ST_HIT +: 8] = r.hit;
						d.prdata[ST_RET +: 8] = r.ret;
						d.pslverr = pwrite;
					end
					// same field position as in status, so one mask serves both
					OFF_IAR: d.prdata[ST_IAR +: 8] = r.iar;
					// unmapped words read as zero and answer with an error
					default: d.pslverr = 1'b1;
				endcase
			end
			// writes while an instruction runs would tear its operands
			if (pwrite && busy)
				d.pslverr = 1'b1;
		end

		start = 1'b0;
		if (wr && !is_mem) begin
			case (paddr)
				OFF_CTRL: begin
					d.scan = pwdata[CTRL_SCAN +: 2];
					d.ovf = pwdata[CTRL_OVF];
					start = pwdata[CTRL_START];
				end
				OFF_INSTR: begin
					d.op = pwdata[IN_OP +: 8];
					d.af = pwdata[IN_AF +: 8];
					d.bf = pwdata[IN_BF +: 8];
				end
				OFF_ADDR: begin
					d.a = pwdata[AD_A +: 8];
					d.b = pwdata[AD_B +: 8];
					d.c = pwdata[AD_C +: 8];
				end
				OFF_IAR: d.iar = pwdata[ST_IAR +: 8];
				default: begin
				end
			endcase
		end

		mem_we = wr & is_mem;
		mem_wa = paddr[9:2];
		mem_wd = pwdata[7:0];

		case (r.state)
			S_IDLE: begin
				if (start) begin
					d.i = '0;
					d.k = '0;
					d.err = 1'b0;
					case (r.op)
						OP_NO_OPERATION: d.iar = 8'(r.iar + step);
						OP_BRANCH_IF_LOW, OP_BRANCH_IF_EQUAL,
						OP_BRANCH_IF_LOW_OR_EQUAL, OP_BRANCH_IF_HIGH,
						OP_BRANCH_IF_DIFFERS, OP_BRANCH_IF_HIGH_OR_EQUAL,
						OP_BRANCH_ALWAYS, OP_BRANCH_ON_OVERFLOW: begin
							// flags as they stood before the start write; an overflow
							// written together with start is seen by the next branch
							d.iar = branch_taken(r.op, r.ind, r.ovf) ?
								r.a : 8'(r.iar + step);
						end
						OP_SUBROUTINE_ENTRY: begin
							d.ret = 8'(r.iar + step + param_count(r.af, r.bf));
							d.iar = r.a;
						end
						OP_COMPARE_ALPHANUMERIC, OP_COMPARE_NUMERIC:
							d.state = S_CMP;
						OP_FIELD_SCAN_MASK: begin
							d.state = S_CMP;
							d.p = r.b;
							d.found = 1'b0;
							d.hit = '0;
						end
						OP_FIELD_XOR: d.state = S_XOR;
						OP_FORMAT_EDIT: d.state = S_EDIT;
						default: d.err = 1'b1;
					endcase
				end
			end
			S_CMP: begin
				if (lt || gt || last) begin
					if (r.op == OP_FIELD_SCAN_MASK) begin
						d.state = S_SCAN_NEXT;
						case (r.scan)
							SCAN_EQUAL: begin
								if (!lt && !gt) begin
									d.found = 1'b1;
									d.hit = r.p;
									d.ind = IND_EQUAL;
									d.state = S_IDLE;
									d.iar = 8'(r.iar + step);
								end
							end
							SCAN_LOW: begin
								if (lt) begin
									d.found = 1'b1;
									d.hit = r.p;
									d.ind = IND_LOW;
									d.state = S_IDLE;
									d.iar = 8'(r.iar + step);
								end
							end
							default: begin
								// lowest ignores the mask once a first entry is held
								if (!r.found || lt) begin
									d.found = 1'b1;
									d.best = r.p;
									d.hit = r.p;
								end
							end
						endcase
					end else begin
						d.ind = lt ? IND_LOW : (gt ? IND_HIGH : IND_EQUAL);
						d.state = S_IDLE;
						d.iar = 8'(r.iar + step);
					end
				end else begin
					d.i = 7'(r.i + 7'h01);
				end
			end
			S_SCAN_NEXT: begin
				d.i = '0;
				// an entry past C or an address wrap ends the scan
				if (nxt[8] || nxt[7:0] > r.c) begin
					// after a lowest scan, equal only says an entry was seen
					d.ind = r.found ? IND_EQUAL : IND_HIGH;
					d.state = S_IDLE;
					d.iar = 8'(r.iar + step);
				end else begin
					d.p = nxt[7:0];
					d.state = S_CMP;
				end
			end
			S_XOR: begin
				mem_we = 1'b1;
				mem_wa = 8'(r.c + {1'b0, r.i});
				mem_wd = xb ^ yb;
				if (last) begin
					d.state = S_IDLE;
					d.iar = 8'(r.iar + step);
				end else begin
					d.i = 7'(r.i + 7'h01);
				end
			end
			S_EDIT: begin
				mem_we = 1'b1;
				mem_wa = 8'(r.c + {1'b0, r.i});
				mem_wd = mo;
				// a copy consumes the next data byte; others go in literally
				if (mo == MO_COPY) begin
					mem_wd = mem[8'(r.a + {1'b0, r.k})];
					d.k = 7'(r.k + 7'h01);
				end
				if (r.i == 7'(yl - 7'h01)) begin
					d.state = S_IDLE;
					d.iar = 8'(r.iar + step);
				end else begin
					d.i = 7'(r.i + 7'h01);
				end
			end
			default: d.state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			r <= REGS_RESET;
		else
			r <= d;
	end

	// core store has no reset; its content is undefined until loaded
	always_ff @(posedge clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
endmodule // compare_branch_logic_exec

// file: bench/compare_branch_chk.sv
`timescale 1ns/100ps
module compare_branch_chk
	import compare_branch_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [APB_DW-1:0] pwdata,
	input wire logic [APB_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic done;
	logic rd;
	logic ovf_q;
	logic brv_q;
	logic [7:0] a_q;
	logic [7:0] op_q;
	assign done = psel && penable && pready;
	assign rd = pready && !pwrite;
	// only accepted writes count; refused ones leave state alone
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ovf_q <= 1'b0;
			brv_q <= 1'b0;
			a_q <= 8'h00;
			op_q <= 8'h00;
		end else if (done && pwrite && !pslverr) begin
			if (paddr == OFF_INSTR)
				op_q <= pwdata[7:0];
			if (paddr == OFF_ADDR)
				a_q <= pwdata[7:0];
			if (paddr == OFF_CTRL) begin
				ovf_q <= pwdata[CTRL_OVF];
				brv_q <= pwdata[CTRL_START] && op_q == OP_BRANCH_ALWAYS;
			end
			if (paddr == OFF_IAR || paddr == OFF_ADDR)
				brv_q <= 1'b0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_rdata_idle: assert property (!pready |-> prdata == '0)
		else $error("read data outside access");
	a_unmapped_err: assert property (psel && !penable &&
		paddr inside {[12'h014:12'h3FF]} |=> pslverr)
		else $error("unmapped access not refused");
	a_status_ro: assert property (psel && !penable && pwrite &&
		paddr == OFF_STATUS |=> pslverr)
		else $error("status write not refused");
	a_ind_legal: assert property (
		rd && paddr == OFF_STATUS |-> prdata[ST_IND+:2] != 2'h0)
		else $error("indicators hold no state");
	a_ovf_seen: assert property (
		rd && paddr == OFF_STATUS |-> prdata[ST_OVF] == ovf_q)
		else $error("overflow flag lost");
	a_branch_target: assert property (
		brv_q && rd && paddr == OFF_IAR |-> prdata[ST_IAR+:8] == a_q)
		else $error("unconditional branch missed");
	a_mem_byte: assert property (
		rd && paddr[11:10] == 2'b01 |-> prdata[31:8] == 24'h0)
		else $error("memory word upper bits set");
	a_start_clear: assert property (
		rd && paddr == OFF_CTRL |-> !prdata[CTRL_START])
		else $error("start bit reads back");
	cover property (done && pwrite && paddr == OFF_CTRL && pwdata[0]);
	cover property (pready && pslverr);
	cover property (brv_q && done && paddr == OFF_IAR);
endmodule // compare_branch_chk

bind compare_branch_logic_exec compare_branch_chk compare_branch_chk_inst (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

// file: bench/core_image.sv
`timescale 1ns/100ps
module core_image
	import compare_branch_pkg::*;
(
	input wire logic clk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [APB_DW-1:0] pwdata
);
	// operands as loaded; results written by the block are not mirrored
	logic [7:0] img [MEM_DEPTH];
	always @(posedge clk)
		if (psel && penable && pready && pwrite && paddr[11:10] == 2'b01)
			img[paddr[9:2]] <= pwdata[7:0];
endmodule // core_image

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
	import compare_branch_pkg::*;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, er, ov, ovp;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, st;
	logic [7:0] x, y, p, t;
	logic [1:0] ind;
	int fails, checks_done;
	compare_branch_logic_exec compare_branch_logic_exec_inst (.clk(clk),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	core_image core_image_inst (.clk(clk), .psel(psel), .penable(penable),
		.pready(pready), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %0t got %h want %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic results;
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic xf(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic mw(input logic [7:0] k, input logic [7:0] v);
		xf(OFF_MEM + {2'h0, k, 2'h0}, 1'b1, {24'h0, v});
	endtask
	task automatic mr(input logic [7:0] k);
		xf(OFF_MEM + {2'h0, k, 2'h0}, 1'b0, '0);
	endtask
	// polls busy; compare and xor take a variable number of cycles
	task automatic run(input logic [7:0] op, af, bf, a, b, c,
		input logic [2:0] o);
		xf(OFF_INSTR, 1'b1, {8'h00, bf, af, op});
		xf(OFF_ADDR, 1'b1, {8'h00, c, b, a});
		xf(OFF_CTRL, 1'b1, {28'h0, o, 1'b1});
		for (int n = 0; n < 3000; n++) begin
			xf(OFF_STATUS, 1'b0, '0);
			st = q;
			if (!st[ST_BUSY])
				break;
		end
		if (st[ST_BUSY]) begin
			fails++;
			results;
		end
	endtask
	function automatic logic take(input logic [7:0] op,
		input logic [1:0] i, input logic o);
		case (op)
			OP_BRANCH_IF_LOW: take = i == IND_LOW;
			OP_BRANCH_IF_EQUAL: take = i == IND_EQUAL;
			OP_BRANCH_IF_LOW_OR_EQUAL: take = i != IND_HIGH;
			OP_BRANCH_IF_HIGH: take = i == IND_HIGH;
			OP_BRANCH_IF_DIFFERS: take = i != IND_EQUAL;
			OP_BRANCH_IF_HIGH_OR_EQUAL: take = i != IND_LOW;
			OP_BRANCH_ALWAYS: take = 1'b1;
			OP_BRANCH_ON_OVERFLOW: take = o;
			default: take = 1'b0;
		endcase
	endfunction
	function automatic logic [1:0] cmpx(input int a, input int b);
		return a < b ? IND_LOW : a == b ? IND_EQUAL : IND_HIGH;
	endfunction
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#800000;
		fails++;
		results;
	end
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		fails = 0;
		checks_done = 0;
		void'($urandom(32'h8DE2));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		xf(OFF_STATUS, 1'b0, '0);
		chk(q, 32'h2);
		xf(12'h020, 1'b0, '0);
		chk({er, q[30:0]}, 32'h80000000);
		xf(OFF_STATUS, 1'b1, '1);
		chk(er, 1'b1);
		for (int r = 0; r < 6; r++) begin
			y = 8'($urandom_range(1, 254));
			x = r < 3 ? y + 8'(r) - 8'h01 : 8'($urandom);
			mw(8'h10, x);
			mw(8'h11, y);
			run(OP_COMPARE_ALPHANUMERIC, 8'h01, 8'h01, 8'h10, 8'h11, 8'h00, 0);
			ind = cmpx(x, y);
			chk(st[1:0], ind);
			ovp = 1'b0;
			for (logic [7:0] op = 8'h20; op <= 8'h28; op++) begin
				p = 8'($urandom);
				t = 8'($urandom);
				ov = 1'($urandom);
				xf(OFF_IAR, 1'b1, {16'h0, p, 8'h00});
				run(op, 8'h00, 8'h00, t, 8'h00, 8'h00, {ov, 2'h0});
				xf(OFF_IAR, 1'b0, '0);
				t = take(op, ind, ovp) ? t : 8'(p + 8'h06);
				chk(q, {16'h0, t, 8'h00});
				ovp = ov;
			end
			chk(st[1:0], ind);
		end
		// one digit against two digits: leading zeros on the short side
		for (int r = 0; r < 4; r++) begin
			x = 8'($urandom_range(0, 9));
			y = r == 0 ? x : 8'($urandom_range(0, 9));
			mw(8'h20, {4'hF, x[3:0]});
			mw(8'h30, {7'h78, r[0]});
			mw(8'h31, {4'hF, y[3:0]});
			run(OP_COMPARE_NUMERIC, 8'h01, 8'h02, 8'h20, 8'h30, 8'h00, 0);
			chk(st[1:0], cmpx(x, 10 * r[0] + y));
		end
		for (int k = 0; k < 4; k++) begin
			mw(8'h40 + 8'(k), 8'($urandom));
			mw(8'h50 + 8'(k), 8'($urandom));
			mw(8'h60 + 8'(k), 8'($urandom));
		end
		run(OP_FIELD_XOR, 8'h02, 8'h03, 8'h40, 8'h50, 8'h60, 0);
		for (int k = 0; k < 4; k++) begin
			mr(8'h60 + 8'(k));
			chk(q, k == 3 ? core_image_inst.img[8'h63] :
				(k == 2 ? 8'hFF : core_image_inst.img[8'h40 + k]) ^
				core_image_inst.img[8'h50 + k]);
		end
		mw(8'h70, MO_COPY);
		mw(8'h71, 8'h2C);
		mw(8'h72, MO_COPY);
		mw(8'h78, 8'($urandom));
		mw(8'h79, 8'($urandom));
		run(OP_FORMAT_EDIT, 8'h00, 8'h03, 8'h78, 8'h70, 8'h80, 0);
		for (int k = 0; k < 3; k++) begin
			mr(8'h80 + 8'(k));
			chk(q, k == 1 ? 8'h2C : core_image_inst.img[8'h78 + k / 2]);
		end
		xf(OFF_IAR, 1'b1, 32'h4000);
		run(OP_SUBROUTINE_ENTRY, 8'h00, 8'h05, 8'h90, 8'h00, 8'h00, 0);
		chk({st[31:24], st[15:8]}, 16'h4B90);
		// a unit step would stop at B1; a step of two must skip to B2
		x = 8'($urandom_range(1, 200));
		mw(8'hA0, x);
		mw(8'hB0, x + 8'h01);
		mw(8'hB1, x);
		mw(8'hB2, x);
		mw(8'hB3, x - 8'h01);
		run(OP_FIELD_SCAN_MASK, 8'h01, 8'h02, 8'hA0, 8'hB0, 8'hB3, 0);
		chk({st[23:16], st[4], st[1:0]}, {8'hB2, 1'b1, IND_EQUAL});
		// low and lowest searches both end on the entry below the mask
		for (int s = 1; s < 3; s++) begin
			run(OP_FIELD_SCAN_MASK, 8'h01, 8'h01, 8'hA0, 8'hB0, 8'hB3, 3'(s));
			chk({st[23:16], st[4], st[1:0]},
				{8'hB3, 1'b1, s == 1 ? IND_LOW : IND_EQUAL});
		end
		xf(OFF_CTRL, 1'b0, '0);
		chk(q, 32'h4);
		results;
	end
endmodule // testbench
